// [hdl/cies_params.svh]
// Constants of the interrupt entry sequencer
`ifndef CIES_PARAMS_SVH
`define CIES_PARAMS_SVH
`define CIES_NUM_SRC 8
`define CIES_SRC_W 3
`define CIES_STACK_BYTES 5
`define CIES_QUEUE_BYTES 3
`define CIES_VEC_BYTES 2
`define CIES_VEC_BASE 16'hffe0
`define CIES_SWI_VEC 16'hfffc
`define CIES_CCR_I_BIT 3
`define CIES_CCR_RESET 8'h08
`define CIES_SP_RESET 16'h00ff
`endif

// [hdl/cies_pkg.sv]
// Types of the interrupt entry sequencer
package cies_pkg;
  typedef enum {
    CIES_RUN,
    CIES_STACK,
    CIES_MASK,
    CIES_VECTOR,
    CIES_FILL
  } cies_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic write;
    logic valid;
  } cies_bus_t;
endpackage

// [hdl/cies_sequencer.sv]
// Interrupt acceptance and entry sequencer of an 8-bit core
`timescale 1ns/10ps
`include "cies_params.svh"
// Operation
// - Hardware event sets source status flag
// - Take hardware interrupt only if enabled and unmasked; software interrupts bypass both
// - Reset leaves global mask set
// - Finish current instruction before entry
// - Hardware entry matches software interrupt sequence
// - Stack, mask, vector, then three-byte fill
// - Vector of highest-priority pending source
// - Return restores mask from stacked register
// - Debug module can trigger software interrupt
module cies_sequencer
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [`CIES_NUM_SRC-1:0] EVENT,
  input wire logic [`CIES_NUM_SRC-1:0] ENABLE,
  input wire logic [`CIES_NUM_SRC-1:0] FLAG_CLEAR,
  input wire logic INSTR_DONE,
  input wire logic SWI_EXEC,
  input wire logic DEBUG_SWI,
  input wire logic RETURN_EXEC,
  input wire logic [7:0] STACKED_CCR,
  input wire logic MASK_WRITE,
  input wire logic MASK_VALUE,
  input wire logic [7:0] CORE_REG_BYTE,
  input wire logic BUS_ACK,
  output logic [`CIES_NUM_SRC-1:0] FLAG,
  output logic [7:0] CONDITION_CODE_REGISTER,
  output cies_pkg::cies_bus_t BUS,
  output logic [2:0] STACK_INDEX,
  output logic ENTRY_BUSY,
  output logic QUEUE_LOAD,
  output logic [15:0] VECTOR_TARGET
);
  logic any_request;
  logic [`CIES_SRC_W-1:0] winner;
  logic [`CIES_NUM_SRC-1:0] flag_w;

  cies_source_bank u_bank
  (
    .clk(CLK),
    .reset(RESET),
    .event_in(EVENT),
    .enable_in(ENABLE),
    .clear_in(FLAG_CLEAR),
    .flag(flag_w),
    .any_request(any_request),
    .winner(winner)
  );

  cies_pkg::cies_state_t state;
  cies_pkg::cies_state_t next_state;
  logic [7:0] condition_code_register;
  logic [7:0] next_ccr;
  logic [2:0] count;
  logic [2:0] next_count;
  logic [15:0] sp;
  logic [15:0] next_sp;
  logic [15:0] target;
  logic [15:0] next_target;
  logic [15:0] vec_addr;
  logic [15:0] next_vec_addr;
  logic is_swi;
  logic next_is_swi;
  logic swi_pend;
  logic next_swi_pend;
  cies_pkg::cies_bus_t next_bus;
  logic next_load;
  logic hw_take;

  // Qualified only with local enable and clear global mask
  assign hw_take = any_request & ~condition_code_register[`CIES_CCR_I_BIT];

  always_comb
  begin
    next_state = state;
    next_ccr = condition_code_register;
    next_count = count;
    next_sp = sp;
    next_target = target;
    next_vec_addr = vec_addr;
    next_is_swi = is_swi;
    next_swi_pend = swi_pend | DEBUG_SWI | SWI_EXEC;
    next_bus = '0;
    next_load = 1'b0;
    case (state)
      cies_pkg::CIES_RUN:
      begin
        if (MASK_WRITE)
          next_ccr[`CIES_CCR_I_BIT] = MASK_VALUE;
        if (RETURN_EXEC)
          next_ccr = STACKED_CCR;
        // Entry only at an instruction boundary
        if (INSTR_DONE && (next_swi_pend || hw_take))
        begin
          next_state = cies_pkg::CIES_STACK;
          next_is_swi = next_swi_pend;
          next_swi_pend = 1'b0;
          next_count = 3'd0;
        end
      end
      cies_pkg::CIES_STACK:
      begin
        if (BUS_ACK)
        begin
          next_sp = sp - 16'h0001;
          next_count = count + 3'd1;
          if (count == 3'(`CIES_STACK_BYTES - 1))
            next_state = cies_pkg::CIES_MASK;
        end
      end
      cies_pkg::CIES_MASK:
      begin
        next_ccr[`CIES_CCR_I_BIT] = 1'b1;
        next_count = 3'd0;
        // Priority is sampled at vector time, not at acceptance
        next_vec_addr = is_swi ? `CIES_SWI_VEC : (`CIES_VEC_BASE + {12'h000, winner, 1'b0});
        next_state = cies_pkg::CIES_VECTOR;
      end
      cies_pkg::CIES_VECTOR:
      begin
        if (BUS_ACK)
        begin
          next_target = {target[7:0], CORE_REG_BYTE};
          next_count = count + 3'd1;
          if (count == 3'(`CIES_VEC_BYTES - 1))
          begin
            next_count = 3'd0;
            next_state = cies_pkg::CIES_FILL;
          end
        end
      end
      cies_pkg::CIES_FILL:
      begin
        if (BUS_ACK)
        begin
          next_load = 1'b1;
          next_count = count + 3'd1;
          if (count == 3'(`CIES_QUEUE_BYTES - 1))
            next_state = cies_pkg::CIES_RUN;
        end
      end
      default:
        next_state = cies_pkg::CIES_RUN;
    endcase
    // The bus word is launched for the state being entered, so it rises with
    // ENTRY_BUSY and an ack always retires the word that is on show
    if (BUS.valid && !BUS_ACK)
      next_bus = BUS;
    else
    begin
      case (next_state)
        cies_pkg::CIES_STACK:
        begin
          next_bus.valid = 1'b1;
          next_bus.write = 1'b1;
          next_bus.addr = next_sp;
          // Stack data is captured once, then held until the ack
          next_bus.wdata = (next_count == 3'(`CIES_STACK_BYTES - 1)) ? next_ccr : CORE_REG_BYTE;
        end
        cies_pkg::CIES_VECTOR:
        begin
          next_bus.valid = 1'b1;
          next_bus.addr = next_vec_addr + {13'h0000, next_count};
        end
        cies_pkg::CIES_FILL:
        begin
          next_bus.valid = 1'b1;
          next_bus.addr = next_target + {13'h0000, next_count};
        end
        default:
          next_bus = '0;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      state <= cies_pkg::CIES_RUN;
      condition_code_register <= `CIES_CCR_RESET;
      count <= 3'd0;
      sp <= `CIES_SP_RESET;
      target <= 16'h0000;
      vec_addr <= 16'h0000;
      is_swi <= 1'b0;
      swi_pend <= 1'b0;
      BUS <= '0;
      QUEUE_LOAD <= 1'b0;
    end
    else
    begin
      state <= next_state;
      condition_code_register <= next_ccr;
      count <= next_count;
      sp <= next_sp;
      target <= next_target;
      vec_addr <= next_vec_addr;
      is_swi <= next_is_swi;
      swi_pend <= next_swi_pend;
      BUS <= next_bus;
      QUEUE_LOAD <= next_load;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      FLAG <= '0;
      CONDITION_CODE_REGISTER <= `CIES_CCR_RESET;
      STACK_INDEX <= 3'd0;
      ENTRY_BUSY <= 1'b0;
      VECTOR_TARGET <= 16'h0000;
    end
    else
    begin
      FLAG <= flag_w;
      CONDITION_CODE_REGISTER <= next_ccr;
      STACK_INDEX <= next_count;
      ENTRY_BUSY <= (next_state != cies_pkg::CIES_RUN);
      VECTOR_TARGET <= next_target;
    end
  end
endmodule

// [hdl/cies_source_bank.sv]
// Interrupt source flags, enables and priority pick
`timescale 1ns/10ps
`include "cies_params.svh"
module cies_source_bank
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [`CIES_NUM_SRC-1:0] event_in,
  input wire logic [`CIES_NUM_SRC-1:0] enable_in,
  input wire logic [`CIES_NUM_SRC-1:0] clear_in,
  output logic [`CIES_NUM_SRC-1:0] flag,
  output logic any_request,
  output logic [`CIES_SRC_W-1:0] winner
);
  logic [`CIES_NUM_SRC-1:0] next_flag;
  logic [`CIES_NUM_SRC-1:0] request;

  // Lowest index is highest priority
  function automatic logic [`CIES_SRC_W-1:0] pick(input logic [`CIES_NUM_SRC-1:0] req);
    logic [`CIES_SRC_W-1:0] idx;
    idx = '0;
    for (int i = `CIES_NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
        idx = i[`CIES_SRC_W-1:0];
    end
    return idx;
  endfunction

  genvar g;
  generate
    for (g = 0; g < `CIES_NUM_SRC; g++)
    begin : gen_src
      // Set wins over clear so an event is never lost
      always_comb
      begin
        next_flag[g] = flag[g];
        if (clear_in[g])
          next_flag[g] = 1'b0;
        if (event_in[g])
          next_flag[g] = 1'b1;
      end
      assign request[g] = flag[g] & enable_in[g];
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (reset)
      flag <= '0;
    else
      flag <= next_flag;
  end

  assign any_request = |request;
  assign winner = pick(request);
endmodule

// [testbench/cies_partner_model.sv]
// Interrupt sources, debug trigger and memory responder facing the sequencer
`timescale 1ns/10ps
module cies_partner_model
(
  input wire logic clk,
  input wire cies_pkg::cies_bus_t bus,
  input wire logic slow,
  input wire logic [7:0] fire,
  input wire logic fire_dbg,
  output logic [7:0] event_out,
  output logic debug_out,
  output logic ack,
  output logic [7:0] rdata
);
  logic hold;
  initial {event_out, debug_out, ack, hold} = 0;
  always @(posedge clk)
  begin
    event_out <= fire;
    debug_out <= fire_dbg;
    hold <= slow & ~hold;
    ack <= bus.valid & ~ack & ~(slow & ~hold);
  end
  // Idle read bus shows the inverse, so a stale byte never passes
  assign rdata = bus.valid ? bus.addr[7:0] ^ 8'h3c : ~(bus.addr[7:0] ^ 8'h3c);
endmodule

// [testbench/cies_sequencer_properties.sv]
// Port checks of the interrupt entry sequencer
`timescale 1ns/10ps
module cies_seq_chk
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] EVENT,
  input wire logic INSTR_DONE,
  input wire logic RETURN_EXEC,
  input wire logic [7:0] STACKED_CCR,
  input wire logic MASK_WRITE,
  input wire logic MASK_VALUE,
  input wire logic BUS_ACK,
  input wire logic [7:0] FLAG,
  input wire logic [7:0] CONDITION_CODE_REGISTER,
  input wire cies_pkg::cies_bus_t BUS,
  input wire logic ENTRY_BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_reset_mask: assert property (disable iff (1'b0) RESET |=> CONDITION_CODE_REGISTER[3])
    else $error("mask clear after reset");
  chk_flag_set: assert property (EVENT != 0 |-> ##2 (FLAG & $past(EVENT, 2)) == $past(EVENT, 2))
    else $error("event did not set flag");
  chk_idle_hold: assert property (!INSTR_DONE && !ENTRY_BUSY |=> !ENTRY_BUSY)
    else $error("entry began mid instruction");
  chk_entry_write: assert property ($rose(ENTRY_BUSY) |-> BUS.valid && BUS.write)
    else $error("entry did not open with a stack write");
  chk_exit_mask: assert property ($fell(ENTRY_BUSY) |-> CONDITION_CODE_REGISTER[3])
    else $error("mask clear after entry");
  chk_bus_stand: assert property (BUS.valid && !BUS_ACK |=> $stable(BUS))
    else $error("bus cycle changed before ack");
  chk_return_mask: assert property (RETURN_EXEC && !ENTRY_BUSY && !MASK_WRITE
    |=> CONDITION_CODE_REGISTER == $past(STACKED_CCR))
    else $error("return did not restore ccr");
  chk_mask_write: assert property (MASK_WRITE && !ENTRY_BUSY && !RETURN_EXEC
    |=> CONDITION_CODE_REGISTER[3] == $past(MASK_VALUE))
    else $error("mask write lost");
endmodule
bind cies_sequencer cies_seq_chk chk_u (.*);

// [testbench/cies_sequencer_test.sv]
// Self-checking bench of the interrupt entry sequencer
`timescale 1ns/10ps
module cies_sequencer_test;
  logic CLK = 0, RESET = 1, INSTR_DONE = 0, SWI_EXEC = 0, RETURN_EXEC = 0;
  logic MASK_WRITE = 0, MASK_VALUE = 0, slow = 0, fire_dbg = 0;
  logic DEBUG_SWI, BUS_ACK, ENTRY_BUSY, QUEUE_LOAD;
  logic [7:0] ENABLE = 0, FLAG_CLEAR = 0, STACKED_CCR = 0, fire = 0, ev;
  logic [7:0] EVENT, CORE_REG_BYTE, FLAG, CONDITION_CODE_REGISTER;
  logic [2:0] STACK_INDEX;
  logic [15:0] VECTOR_TARGET;
  cies_pkg::cies_bus_t BUS;
  int n_fail = 0, checked = 0, nw = 0, nq = 0, nw0, nq0, cyc = 0, w;
  integer seed = 32'hb127;
  cies_sequencer dut_u (.*);
  cies_partner_model part_u (.clk(CLK), .bus(BUS), .slow(slow), .fire(fire),
    .fire_dbg(fire_dbg), .event_out(EVENT), .debug_out(DEBUG_SWI), .ack(BUS_ACK),
    .rdata(CORE_REG_BYTE));
  initial forever #5 CLK = ~CLK;
  task finish_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  function automatic int low(input logic [7:0] v);
    low = 0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        low = i;
  endfunction
  task automatic entry(input logic [15:0] va);
    nw0 = nw;
    nq0 = nq;
    slow = 1'($random(seed));
    pulse(INSTR_DONE);
    tick(1);
    chk(ENTRY_BUSY, 1);
    for (int i = 0; i < 300 && ENTRY_BUSY !== 0; i++)
      tick(1);
    tick(1);
    chk(VECTOR_TARGET, {va[7:0] ^ 8'h3c, (va[7:0] + 8'h01) ^ 8'h3c});
    chk(nw - nw0, 5);
    chk(nq - nq0, 3);
    chk(STACK_INDEX, 3);
    chk(CONDITION_CODE_REGISTER[3], 1);
  endtask
  always @(posedge CLK)
  begin
    nw <= nw + (BUS.valid && BUS_ACK && BUS.write);
    nq <= nq + QUEUE_LOAD;
    cyc <= cyc + 1;
    // Whole run needs a few hundred cycles; far above that means a hang
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test;
    end
  end
  initial
  begin
    tick(2);
    RESET = 0;
    chk(CONDITION_CODE_REGISTER, 8'h08);
    ENABLE = 8'hff;
    ev = 8'($random(seed)) | 8'he0;
    fire = ev;
    tick(1);
    fire = 0;
    tick(3);
    chk(FLAG, ev);
    pulse(INSTR_DONE);
    tick(3);
    chk(ENTRY_BUSY, 0);
    pulse(MASK_WRITE);
    chk(CONDITION_CODE_REGISTER[3], 0);
    for (int k = 0; k < 3; k++)
    begin
      w = low(ev);
      entry(16'hffe0 + 16'(2 * w));
      STACKED_CCR = 8'($random(seed)) & 8'hf7;
      pulse(RETURN_EXEC);
      chk(CONDITION_CODE_REGISTER, STACKED_CCR);
      // First pass keeps the flag so the same source must win again
      if (k > 0)
      begin
        FLAG_CLEAR[w] = 1;
        ev[w] = 0;
        tick(1);
        FLAG_CLEAR = 0;
        tick(2);
        chk(FLAG, ev);
      end
    end
    ENABLE = 0;
    pulse(INSTR_DONE);
    tick(2);
    chk(ENTRY_BUSY, 0);
    pulse(SWI_EXEC);
    entry(16'hfffc);
    pulse(fire_dbg);
    tick(2);
    entry(16'hfffc);
    finish_test;
  end
endmodule
